// ### core/tdcw_byte_fetch.sv
// Byte fetcher: reads one fragment's buffer word by word and streams its bytes.
`include "tdcw_defs.svh"

module tdcw_byte_fetch (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Walker link
  tdcw_fetch_if.fetcher fif,
  // Transmit byte stream
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_first,
  output logic tx_last
);

  // ===================================================================
  // Byte lane selection, little-endian within a word
  function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] lane);
    logic [7:0] b;
    b = w[7:0];
    unique case (lane)
      2'h0: b = w[7:0];
      2'h1: b = w[15:8];
      2'h2: b = w[23:16];
      2'h3: b = w[31:24];
    endcase
    return b;
  endfunction

  tdcw_pkg::tdcw_fstate_t st_q;
  logic [29:0] waddr_q;
  logic [1:0] lane_q;
  logic [15:0] left_q;
  logic [31:0] word_q;
  logic first_q;
  logic lastf_q;
  logic req_q;
  logic done_q;
  logic valid_q;
  logic [7:0] data_q;
  logic txf_q;
  logic txl_q;

  assign fif.done = done_q;
  assign fif.word_req = req_q;
  assign fif.word_addr = waddr_q;
  assign tx_valid = valid_q;
  assign tx_data = data_q;
  assign tx_first = txf_q;
  assign tx_last = txl_q;

  // ===================================================================
  // Fetch sequencing
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= tdcw_pkg::F_IDLE;
      waddr_q <= 30'h0;
      lane_q <= 2'h0;
      left_q <= `TDCW_LEN_RST;
      word_q <= `TDCW_WORD_RST;
      first_q <= 1'b0;
      lastf_q <= 1'b0;
      req_q <= 1'b0;
      done_q <= 1'b0;
      valid_q <= 1'b0;
      data_q <= 8'h00;
      txf_q <= 1'b0;
      txl_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (st_q)
        tdcw_pkg::F_IDLE: begin
          if (fif.start) begin
            // Any byte address is a legal start; the low bits pick the first lane.
            waddr_q <= fif.addr[31:2];
            lane_q <= fif.addr[1:0];
            left_q <= fif.len;
            first_q <= fif.frag_first;
            lastf_q <= fif.frag_last;
            if (fif.len == `TDCW_LEN_RST) begin
              done_q <= 1'b1;
            end else begin
              req_q <= 1'b1;
              st_q <= tdcw_pkg::F_REQ;
            end
          end
        end
        tdcw_pkg::F_REQ: begin
          if (fif.word_ack) begin
            req_q <= 1'b0;
            word_q <= fif.word_data;
            valid_q <= 1'b1;
            data_q <= pick(fif.word_data, lane_q);
            txf_q <= first_q;
            txl_q <= lastf_q && (left_q == 16'h0001);
            st_q <= tdcw_pkg::F_BYTE;
          end
        end
        tdcw_pkg::F_BYTE: begin
          if (tx_ready) begin
            first_q <= 1'b0;
            txf_q <= 1'b0;
            left_q <= left_q - 16'h0001;
            if (left_q == 16'h0001) begin
              valid_q <= 1'b0;
              txl_q <= 1'b0;
              done_q <= 1'b1;
              st_q <= tdcw_pkg::F_IDLE;
            end else if (lane_q == `TDCW_LANE_LAST) begin
              valid_q <= 1'b0;
              lane_q <= 2'h0;
              waddr_q <= waddr_q + 30'h1;
              req_q <= 1'b1;
              st_q <= tdcw_pkg::F_REQ;
            end else begin
              lane_q <= lane_q + 2'h1;
              data_q <= pick(word_q, lane_q + 2'h1);
              txl_q <= lastf_q && (left_q == 16'h0002);
            end
          end
        end
        default: st_q <= tdcw_pkg::F_IDLE;
      endcase
    end
  end

endmodule

// ### core/tdcw_defs.svh
// Descriptor word indices, flag bit positions and reset values for the transmit chain walker.
`ifndef TDCW_DEFS_SVH
`define TDCW_DEFS_SVH

// =====================================================================
// Descriptor word indices
`define TDCW_W_NEXT 2'h0
`define TDCW_W_BUF 2'h1
`define TDCW_W_OFFLEN 2'h2
`define TDCW_W_FLGLEN 2'h3

// =====================================================================
// Field positions
`define TDCW_BIT_FIRST 31
`define TDCW_BIT_LAST 30
`define TDCW_BIT_HOLD 29
`define TDCW_BIT_QEND 28
`define TDCW_BIT_ABORT 27
`define TDCW_BIT_FCS 26
`define TDCW_HI_MSB 31
`define TDCW_HI_LSB 16
`define TDCW_LO_MSB 15
`define TDCW_LO_LSB 0

// =====================================================================
// Values
`define TDCW_LINK_NULL 32'h0000_0000
`define TDCW_WORD_RST 32'h0000_0000
`define TDCW_LEN_RST 16'h0000
`define TDCW_LANE_LAST 2'h3

`endif

// ### core/tdcw_fetch_if.sv
// Link between the descriptor walker and the buffer byte fetcher.
interface tdcw_fetch_if;
  logic start;
  logic [31:0] addr;
  logic [15:0] len;
  logic frag_first;
  logic frag_last;
  logic done;
  logic word_req;
  logic [29:0] word_addr;
  logic word_ack;
  logic [31:0] word_data;

  modport walker (
    output start, addr, len, frag_first, frag_last, word_ack, word_data,
    input done, word_req, word_addr
  );

  modport fetcher (
    input start, addr, len, frag_first, frag_last, word_ack, word_data,
    output done, word_req, word_addr
  );
endinterface

// ### core/tdcw_pkg.sv
// Types shared by the transmit chain walker and its byte fetcher.
package tdcw_pkg;

  // ===================================================================
  // Walker states
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_RD   = 3'h1,
    S_DATA = 3'h2,
    S_WEND = 3'h3,
    S_WSOP = 3'h4,
    S_WABT = 3'h5
  } tdcw_state_t;

  // ===================================================================
  // Fetcher states
  typedef enum logic [1:0] {
    F_IDLE = 2'h0,
    F_REQ  = 2'h1,
    F_BYTE = 2'h2
  } tdcw_fstate_t;

endpackage

// ### core/tx_descriptor_chain_walker.sv
// Transmit descriptor chain walker: follows linked descriptors and streams packet bytes.
// What this block does
// - A zero next link ends the queue; non-zero links are followed; link never written.
// - A link appended before it is read is followed; else the channel halts.
// - Any byte address is accepted as buffer start; that word is never written.
// - The offset field gives how many leading buffer bytes are skipped.
// - Offset applies only on the first fragment and is never written.
// - Exactly buffer-length valid bytes are fetched from each fragment.
// - Packet length is taken only from the first fragment and never written.
// - First and last fragment flags are never modified.
// - The hold flag in the first descriptor is cleared when the packet is done.
// - Queue end flag is set on a last fragment whose next link is zero.
// - On teardown only the first unsent packet gets the abort flag; nothing follows.
// - Offset and packet flags sit in upper halves, lengths in lower halves.
// - Each descriptor is read as four consecutive aligned words in order.
// - After a queue end halt, a new head pointer write restarts the walk.
// - With the supplied-check flag set no check sequence is appended, else it is.
`include "tdcw_defs.svh"

module tx_descriptor_chain_walker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Channel control
  input wire logic head_wr,
  input wire logic [31:0] head_addr,
  input wire logic teardown_req,
  // Channel status
  output logic busy,
  output logic halted,
  output logic teardown_done,
  output logic [15:0] pkt_len,
  output logic fcs_append,
  // Descriptor and buffer memory
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Transmit byte stream
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_first,
  output logic tx_last
);

  // ===================================================================
  // Helpers
  function automatic logic [31:0] word_at(input logic [31:0] base, input logic [1:0] idx);
    return {base[31:2] + {28'h0, idx}, 2'b00};
  endfunction

  // Only the status flags change; every other bit is written back as read.
  function automatic logic [31:0] patch(input logic [31:0] w, input logic qend, input logic hclr,
                                        input logic abort);
    logic [31:0] r;
    r = w;
    if (qend) begin
      r[`TDCW_BIT_QEND] = 1'b1;
    end
    if (hclr) begin
      r[`TDCW_BIT_HOLD] = 1'b0;
    end
    if (abort) begin
      r[`TDCW_BIT_ABORT] = 1'b1;
    end
    return r;
  endfunction

  // ===================================================================
  // State
  tdcw_pkg::tdcw_state_t state_q;
  logic [31:0] desc_q;
  logic [31:0] next_q;
  logic [31:0] buf_q;
  logic [31:0] offlen_q;
  logic [31:0] flg_q;
  logic [31:0] sop_desc_q;
  logic [31:0] sop_flg_q;
  logic [1:0] idx_q;
  logic in_pkt_q;
  logic td_pend_q;
  logic td_clr;
  logic req_q;
  logic we_q;
  logic [31:0] addr_q;
  logic [31:0] wdata_q;
  logic start_q;
  logic [31:0] f_addr_q;
  logic [15:0] f_len_q;
  logic f_first_q;
  logic f_last_q;
  logic wack_q;
  logic [31:0] wdat_q;
  logic busy_q;
  logic halted_q;
  logic td_done_q;
  logic [15:0] pkt_len_q;
  logic fcs_app_q;

  tdcw_fetch_if fif ();

  assign fif.start = start_q;
  assign fif.addr = f_addr_q;
  assign fif.len = f_len_q;
  assign fif.frag_first = f_first_q;
  assign fif.frag_last = f_last_q;
  assign fif.word_ack = wack_q;
  assign fif.word_data = wdat_q;

  assign mem_req = req_q;
  assign mem_we = we_q;
  assign mem_addr = addr_q;
  assign mem_wdata = wdata_q;
  assign busy = busy_q;
  assign halted = halted_q;
  assign teardown_done = td_done_q;
  assign pkt_len = pkt_len_q;
  assign fcs_append = fcs_app_q;

  assign td_clr = ((state_q == tdcw_pkg::S_IDLE) && td_pend_q) || ((state_q == tdcw_pkg::S_WABT) && mem_ack);

  tdcw_byte_fetch u_fetch (
    .clk(clk),
    .rst(rst),
    .fif(fif),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_first(tx_first),
    .tx_last(tx_last)
  );

  // ===================================================================
  // Teardown request latch; a new request wins over the clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      td_pend_q <= 1'b0;
    end else if (teardown_req) begin
      td_pend_q <= 1'b1;
    end else if (td_clr) begin
      td_pend_q <= 1'b0;
    end
  end

  // ===================================================================
  // Status outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      td_done_q <= 1'b0;
    end else begin
      busy_q <= (state_q != tdcw_pkg::S_IDLE);
      td_done_q <= td_clr;
    end
  end

  // ===================================================================
  // Chain walk and memory master
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= tdcw_pkg::S_IDLE;
      desc_q <= `TDCW_WORD_RST;
      next_q <= `TDCW_WORD_RST;
      buf_q <= `TDCW_WORD_RST;
      offlen_q <= `TDCW_WORD_RST;
      flg_q <= `TDCW_WORD_RST;
      sop_desc_q <= `TDCW_WORD_RST;
      sop_flg_q <= `TDCW_WORD_RST;
      idx_q <= `TDCW_W_NEXT;
      in_pkt_q <= 1'b0;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= `TDCW_WORD_RST;
      wdata_q <= `TDCW_WORD_RST;
      start_q <= 1'b0;
      f_addr_q <= `TDCW_WORD_RST;
      f_len_q <= `TDCW_LEN_RST;
      f_first_q <= 1'b0;
      f_last_q <= 1'b0;
      wack_q <= 1'b0;
      wdat_q <= `TDCW_WORD_RST;
      halted_q <= 1'b0;
      pkt_len_q <= `TDCW_LEN_RST;
      fcs_app_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      wack_q <= 1'b0;
      unique case (state_q)
        tdcw_pkg::S_IDLE: begin
          req_q <= 1'b0;
          we_q <= 1'b0;
          if (!td_pend_q && head_wr && (head_addr != `TDCW_LINK_NULL)) begin
            desc_q <= {head_addr[31:2], 2'b00};
            idx_q <= `TDCW_W_NEXT;
            in_pkt_q <= 1'b0;
            halted_q <= 1'b0;
            state_q <= tdcw_pkg::S_RD;
          end
        end
        tdcw_pkg::S_RD: begin
          we_q <= 1'b0;
          addr_q <= word_at(desc_q, idx_q);
          if (mem_ack) begin
            req_q <= 1'b0;
            idx_q <= idx_q + 2'h1;
            unique case (idx_q)
              `TDCW_W_NEXT: next_q <= mem_rdata;
              `TDCW_W_BUF: buf_q <= mem_rdata;
              `TDCW_W_OFFLEN: offlen_q <= mem_rdata;
              `TDCW_W_FLGLEN: flg_q <= mem_rdata;
            endcase
            if (idx_q == `TDCW_W_FLGLEN) begin
              f_len_q <= offlen_q[`TDCW_LO_MSB:`TDCW_LO_LSB];
              f_last_q <= mem_rdata[`TDCW_BIT_LAST];
              if (in_pkt_q) begin
                f_addr_q <= buf_q;
                f_first_q <= 1'b0;
                start_q <= 1'b1;
                state_q <= tdcw_pkg::S_DATA;
              end else if (!mem_rdata[`TDCW_BIT_FIRST] || !mem_rdata[`TDCW_BIT_HOLD]) begin
                halted_q <= 1'b1;
                state_q <= tdcw_pkg::S_IDLE;
              end else if (td_pend_q) begin
                state_q <= tdcw_pkg::S_WABT;
              end else begin
                f_addr_q <= buf_q + {16'h0000, offlen_q[`TDCW_HI_MSB:`TDCW_HI_LSB]};
                f_first_q <= 1'b1;
                start_q <= 1'b1;
                sop_desc_q <= desc_q;
                sop_flg_q <= mem_rdata;
                pkt_len_q <= mem_rdata[`TDCW_LO_MSB:`TDCW_LO_LSB];
                fcs_app_q <= !mem_rdata[`TDCW_BIT_FCS];
                in_pkt_q <= 1'b1;
                state_q <= tdcw_pkg::S_DATA;
              end
            end
          end else begin
            req_q <= 1'b1;
          end
        end
        tdcw_pkg::S_DATA: begin
          if (mem_ack) begin
            req_q <= 1'b0;
            wack_q <= 1'b1;
            wdat_q <= mem_rdata;
          end else if (fif.word_req && !req_q && !wack_q) begin
            req_q <= 1'b1;
            we_q <= 1'b0;
            addr_q <= {fif.word_addr, 2'b00};
          end
          if (fif.done) begin
            if (flg_q[`TDCW_BIT_LAST]) begin
              // Write-back waits for the whole packet to be fetched.
              state_q <= ((next_q == `TDCW_LINK_NULL) || (desc_q == sop_desc_q)) ?
                         tdcw_pkg::S_WEND : tdcw_pkg::S_WSOP;
            end else if (next_q == `TDCW_LINK_NULL) begin
              halted_q <= 1'b1;
              in_pkt_q <= 1'b0;
              state_q <= tdcw_pkg::S_IDLE;
            end else begin
              desc_q <= next_q;
              idx_q <= `TDCW_W_NEXT;
              state_q <= tdcw_pkg::S_RD;
            end
          end
        end
        tdcw_pkg::S_WEND: begin
          addr_q <= word_at(desc_q, `TDCW_W_FLGLEN);
          wdata_q <= patch(flg_q, next_q == `TDCW_LINK_NULL, desc_q == sop_desc_q, 1'b0);
          if (mem_ack) begin
            req_q <= 1'b0;
            we_q <= 1'b0;
            if (desc_q != sop_desc_q) begin
              state_q <= tdcw_pkg::S_WSOP;
            end else if (next_q == `TDCW_LINK_NULL) begin
              halted_q <= 1'b1;
              in_pkt_q <= 1'b0;
              state_q <= tdcw_pkg::S_IDLE;
            end else begin
              desc_q <= next_q;
              idx_q <= `TDCW_W_NEXT;
              in_pkt_q <= 1'b0;
              state_q <= tdcw_pkg::S_RD;
            end
          end else begin
            req_q <= 1'b1;
            we_q <= 1'b1;
          end
        end
        tdcw_pkg::S_WSOP: begin
          addr_q <= word_at(sop_desc_q, `TDCW_W_FLGLEN);
          wdata_q <= patch(sop_flg_q, 1'b0, 1'b1, 1'b0);
          if (mem_ack) begin
            req_q <= 1'b0;
            we_q <= 1'b0;
            in_pkt_q <= 1'b0;
            if (next_q == `TDCW_LINK_NULL) begin
              halted_q <= 1'b1;
              state_q <= tdcw_pkg::S_IDLE;
            end else begin
              desc_q <= next_q;
              idx_q <= `TDCW_W_NEXT;
              state_q <= tdcw_pkg::S_RD;
            end
          end else begin
            req_q <= 1'b1;
            we_q <= 1'b1;
          end
        end
        tdcw_pkg::S_WABT: begin
          addr_q <= word_at(desc_q, `TDCW_W_FLGLEN);
          wdata_q <= patch(flg_q, 1'b0, 1'b1, 1'b1);
          if (mem_ack) begin
            req_q <= 1'b0;
            we_q <= 1'b0;
            state_q <= tdcw_pkg::S_IDLE;
          end else begin
            req_q <= 1'b1;
            we_q <= 1'b1;
          end
        end
        default: state_q <= tdcw_pkg::S_IDLE;
      endcase
    end
  end

endmodule

// ### sim/tdcw_mem_model.sv
// Shared descriptor and buffer memory with a selectable answer delay.
module tdcw_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Cycles of wait before each ack
  input wire logic [3:0] lat,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:255];
  logic [3:0] wait_q;

  // Outside an ack the read data toggles, so stale data is never mistaken for valid.
  always @(posedge clk) begin
    if (rst || mem_ack || !mem_req) begin
      mem_ack <= 1'b0;
      wait_q <= 4'h0;
      mem_rdata <= rst ? 32'h5a5a_a5a5 : ~mem_rdata;
    end else if (wait_q == lat) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[9:2]];
      if (mem_we) mem[mem_addr[9:2]] <= mem_wdata;
    end else begin
      wait_q <= wait_q + 4'h1;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// ### sim/tdcw_props.sv
// Port-level checker for the transmit descriptor chain walker.
`include "tdcw_defs.svh"

module tdcw_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Channel
  input wire logic head_wr,
  input wire logic [31:0] head_addr,
  input wire logic busy,
  input wire logic halted,
  input wire logic teardown_done,
  // Memory
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  // Stream
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_first,
  input wire logic tx_last
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Tracks whether a packet is open on the byte stream.
  logic in_pkt_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      in_pkt_q <= 1'b0;
    end else if (tx_valid && tx_ready) begin
      in_pkt_q <= !tx_last;
    end
  end

  property p_wr_flags;
    mem_req && mem_we |-> mem_addr[3:2] == `TDCW_W_FLGLEN;
  endproperty
  a_wr_flags: assert property (p_wr_flags) else $error("write outside flags word");
  property p_align;
    mem_req |-> mem_addr[1:0] == 2'h0;
  endproperty
  a_align: assert property (p_align) else $error("unaligned memory address");
  property p_req_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("memory request changed before ack");
  property p_ack_drop;
    mem_ack |=> !mem_req;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request held after ack");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_first) && $stable(tx_last);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("byte changed before accept");
  property p_start;
    $rose(busy) |-> mem_req && !mem_we && $past(head_wr, 2) && mem_addr == ($past(head_addr, 2) & 32'hffff_fffc);
  endproperty
  a_start: assert property (p_start) else $error("walk did not start at head");
  property p_halt_quiet;
    halted && !head_wr && !$past(head_wr) && !$past(head_wr, 2) |=> !mem_req;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("memory traffic while halted");
  property p_td_pulse;
    teardown_done |=> !teardown_done;
  endproperty
  a_td_pulse: assert property (p_td_pulse) else $error("teardown done longer than one cycle");
  property p_frame;
    tx_valid |-> tx_first == !in_pkt_q;
  endproperty
  a_frame: assert property (p_frame) else $error("first byte marker out of place");

  c_last: cover property (tx_valid && tx_ready && tx_last);
  c_td: cover property (teardown_done);
  c_halt: cover property ($rose(halted));
endmodule

bind tx_descriptor_chain_walker tdcw_props chk_u (.clk, .rst, .head_wr, .head_addr, .busy, .halted, .teardown_done,
  .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .tx_ready, .tx_valid, .tx_data, .tx_first, .tx_last);

// ### sim/tx_descriptor_chain_walker_test.sv
// Self-checking bench for the transmit descriptor chain walker.
`include "tdcw_defs.svh"

module tx_descriptor_chain_walker_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] bp1; logic [15:0] ofs, len1; logic [31:0] bp2; logic [15:0] len2;
    logic fcs; logic [3:0] lat; logic stall;} tdcw_row_t;
  localparam logic [31:0] HOLD_M = 32'h1 << `TDCW_BIT_HOLD;
  localparam logic [31:0] QEND_M = 32'h1 << `TDCW_BIT_QEND;
  localparam logic [31:0] ABORT_M = 32'h1 << `TDCW_BIT_ABORT;
  logic clk = 1'b0, rst = 1'b1, head_wr = 1'b0, teardown_req = 1'b0, tx_ready = 1'b0, stall = 1'b0;
  logic [31:0] head_addr = 32'h0000_0000;
  logic [3:0] lat = 4'h0;
  logic busy, halted, teardown_done, fcs_append, mem_req, mem_we, mem_ack, tx_valid, tx_first, tx_last;
  logic [15:0] pkt_len;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, w3a, w3b;
  logic [7:0] tx_data;
  logic [9:0] exp_q [$], got_q [$];
  int num_errors = 0, cmp_count = 0, cycles = 0, td_count = 0;
  tdcw_row_t r;
  tdcw_row_t rows [4] = '{'{32'h200, 16'h0, 16'h5, 32'h0, 16'h0, 1'b0, 4'h0, 1'b0},
    '{32'h241, 16'h000f, 16'h3, 32'h0, 16'h0, 1'b1, 4'h2, 1'b1},
    '{32'h283, 16'h2, 16'h6, 32'h2c1, 16'h4, 1'b0, 4'h1, 1'b1},
    '{32'h302, 16'h0, 16'h1, 32'h343, 16'h9, 1'b1, 4'h3, 1'b0}};

  tx_descriptor_chain_walker dut_u (.clk, .rst, .head_wr, .head_addr, .teardown_req, .busy, .halted, .teardown_done,
    .pkt_len, .fcs_append, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .tx_ready, .tx_valid,
    .tx_data, .tx_first, .tx_last);
  tdcw_mem_model mem_u (.clk, .rst, .lat, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);

  always #20 clk = ~clk;
  always @(negedge clk) tx_ready <= stall ? ~tx_ready : 1'b1;
  always @(posedge clk) begin
    if (!rst && tx_valid === 1'b1 && tx_ready === 1'b1) got_q.push_back({tx_first, tx_last, tx_data});
    if (teardown_done === 1'b1) td_count++;
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      complete_run();
    end
  end

  function automatic logic [7:0] byte_at(input logic [31:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic put_desc(input logic [31:0] a, input logic [31:0] nxt, bp, ol, fl);
    mem_u.mem[a[9:2]] = nxt;
    mem_u.mem[a[9:2] + 8'h1] = bp;
    mem_u.mem[a[9:2] + 8'h2] = ol;
    mem_u.mem[a[9:2] + 8'h3] = fl;
  endtask

  task automatic add_frag(input logic [31:0] a, input logic [15:0] n, input logic f, input logic l);
    for (int i = 0; i < n; i++) exp_q.push_back({f && i == 0, l && i == n - 1, byte_at(a + i)});
  endtask

  task automatic check_stream();
    check("byte count", exp_q.size(), got_q.size());
    foreach (exp_q[i]) if (i < got_q.size()) check("byte", exp_q[i], got_q[i]);
    exp_q.delete();
    got_q.delete();
  endtask

  task automatic go(input logic [31:0] a);
    @(negedge clk);
    head_wr = 1'b1;
    head_addr = a;
    @(negedge clk);
    head_wr = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic settle(input logic want_halt);
    int n;
    n = 0;
    while ((want_halt ? halted !== 1'b1 : busy !== 1'b0) && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check("end of walk", 1, n < 3000);
    repeat (3) @(negedge clk);
  endtask

  task automatic two_chain();
    put_desc(32'h100, 32'h110, 32'h200, 32'h0000_0004, 32'he000_0004);
    put_desc(32'h110, 32'h0, 32'h240, 32'h0000_0003, 32'he000_0003);
    add_frag(32'h200, 16'h4, 1'b1, 1'b1);
  endtask

  task automatic complete_run();
    $display("counts: %0d comparisons, %0d mismatches", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    for (int w = 0; w < 256; w++) mem_u.mem[w] = {byte_at(4*w+3), byte_at(4*w+2), byte_at(4*w+1), byte_at(4*w)};
    repeat (4) @(negedge clk);
    rst = 1'b0;
    check("reset outputs", 0, {busy, halted, teardown_done, mem_req, tx_valid, fcs_append, pkt_len});
    $display("test reset done");
    foreach (rows[i]) begin
      r = rows[i];
      lat = r.lat;
      stall = r.stall;
      w3a = {1'b1, r.len2 == 16'h0, 1'b1, 2'b00, r.fcs, 10'h000, r.len1 + r.len2};
      w3b = {2'b01, 14'h0000, 16'h0077};
      put_desc(32'h100, r.len2 == 16'h0 ? 32'h0 : 32'h110, r.bp1, {r.ofs, r.len1}, w3a);
      put_desc(32'h110, 32'h0, r.bp2, {16'h0005, r.len2}, w3b);
      add_frag(r.bp1 + r.ofs, r.len1, 1'b1, r.len2 == 16'h0);
      if (r.len2 != 16'h0) add_frag(r.bp2, r.len2, 1'b0, 1'b1);
      go(32'h100);
      settle(1'b1);
      check_stream();
      check("pkt_len", r.len1 + r.len2, pkt_len);
      check("fcs_append", !r.fcs, fcs_append);
      check("first link", r.len2 == 16'h0 ? 32'h0 : 32'h110, mem_u.mem[64]);
      check("first buffer", r.bp1, mem_u.mem[65]);
      check("first offlen", {r.ofs, r.len1}, mem_u.mem[66]);
      if (r.len2 == 16'h0) check("first flags", w3a & ~HOLD_M | QEND_M, mem_u.mem[67]);
      else check("first flags", w3a & ~HOLD_M, mem_u.mem[67]);
      if (r.len2 != 16'h0) check("last flags", w3b | QEND_M, mem_u.mem[71]);
      $display("test row %0d done", i);
    end
    lat = 4'h1;
    stall = 1'b1;
    two_chain();
    add_frag(32'h240, 16'h3, 1'b1, 1'b1);
    go(32'h100);
    settle(1'b1);
    check_stream();
    check("chain first flags", 32'hc000_0004, mem_u.mem[67]);
    check("chain last flags", 32'hd000_0003, mem_u.mem[71]);
    $display("test chain done");
    lat = 4'h3;
    two_chain();
    put_desc(32'h110, 32'h120, 32'h240, 32'h0000_0003, 32'he000_0003);
    put_desc(32'h120, 32'h0, 32'h280, 32'h0000_0002, 32'he000_0002);
    go(32'h100);
    // Teardown lands while the first packet streams, so the second packet is the first unsent one.
    while (tx_valid !== 1'b1) @(negedge clk);
    teardown_req = 1'b1;
    @(negedge clk);
    teardown_req = 1'b0;
    settle(1'b0);
    check_stream();
    check("teardown pulses", 1, td_count);
    check("aborted flags", 32'hc800_0003, mem_u.mem[71]);
    check("finished flags", 32'hc000_0004, mem_u.mem[67]);
    check("untouched flags", 32'he000_0002, mem_u.mem[75]);
    $display("test teardown done");
    complete_run();
  end
endmodule
